// File: rtl/mpwm_apb.sv
// APB slave front end: zero wait state, errors on unmapped addresses
`timescale 1ns/1ps
module mpwm_apb (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    mpwm_reg_if.slave rif
);
    import mpwm_pkg::*;

    wire access = psel & penable;
    wire aligned = (paddr[1:0] == 2'b00) & (paddr[11:10] == 2'b00);
    wire [7:0] idx = paddr[9:2];
    wire good = aligned & rif.rd_hit;

    assign rif.rd_idx = idx;
    assign rif.wr_idx = idx;
    assign rif.wr_data = pwdata[7:0];
    // Only the low byte lane carries data; a write without it is ignored
    assign rif.wr_en = access & pwrite & good & pstrb[0];
    assign pready = 1'b1;
    assign pslverr = access & ~good;
    assign prdata = {24'h000000, (access & ~pwrite & good) ? rif.rd_data : 8'h00};
endmodule : mpwm_apb

// File: rtl/mpwm_pkg.sv
// Types shared by the multichannel PWM unit
package mpwm_pkg;
    typedef logic [11:0] mpwm_cnt_t;
    typedef logic [7:0] mpwm_byte_t;
    typedef enum logic [1:0] {
        MPWM_IDLE = 2'b00,
        MPWM_SETUP = 2'b01,
        MPWM_ACCESS = 2'b10
    } mpwm_apb_state_t;
endpackage : mpwm_pkg

// File: rtl/mpwm_reg_if.sv
// Write strobe and read port bundle between the APB slave and the PWM core
`timescale 1ns/1ps
interface mpwm_reg_if;
    logic wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] rd_idx;
    logic [7:0] rd_data;
    logic rd_hit;
    modport slave (output wr_en, output wr_idx, output wr_data, output rd_idx,
        input rd_data, input rd_hit);
    modport core (input wr_en, input wr_idx, input wr_data, input rd_idx,
        output rd_data, output rd_hit);
endinterface : mpwm_reg_if

// File: rtl/mpwm_regs.svh
// Register offsets, field positions and reset values of the multichannel PWM unit
`ifndef MPWM_REGS_SVH
`define MPWM_REGS_SVH

// APB byte addresses are four times the register index
`define MPWM_IDX_PERIOD_LOW 8'hd9
`define MPWM_IDX_CH0_LOW 8'hda
`define MPWM_IDX_CONTROL_ONE 8'hdc
`define MPWM_IDX_CH2_LOW 8'hdd
`define MPWM_IDX_CH6_LOW 8'hde
`define MPWM_IDX_BRAKE_LEVELS 8'hdf
`define MPWM_IDX_HIGH_BITS 8'he8
`define MPWM_IDX_CH_LOW_ODD 8'he9
`define MPWM_IDX_IRQ_STATUS 8'hea
`define MPWM_IDX_IRQ_MASK 8'heb
`define MPWM_IDX_BRAKE_CTL 8'hec
`define MPWM_IDX_CH4_LOW 8'hed

`define MPWM_BIT_RUN 7
`define MPWM_BIT_LOAD 6
`define MPWM_BIT_FLAG 5
`define MPWM_BIT_CLEAR 4

`define MPWM_RST_BYTE 8'h00
`define MPWM_RST_PERIOD 12'hfff
`define MPWM_CNT_W 12
`define MPWM_IRQ_PERIOD 0
`define MPWM_IRQ_LOAD 1

`endif

// File: rtl/mpwm_top.sv
// Multichannel PWM unit with APB registers, brake override and interrupt
//
// Functional notes
// - Run bit 7 of control one lets the counter count; clear holds it.
// - With load set, period and compares copy to working regs at underflow.
// - Hardware clears load once the transfer to working registers happened.
// - With load clear, buffered values never reach working registers.
// - Counter is 12 bits; its underflow is the reload and flag point.
// - Period flag bit 5 set on each underflow; only software clears it.
// - Writing clear bit resets counter to zero; bit then reads zero.
// - Bits 3-0 invert channels 6,4,2,0; one inverts.
// - During brake each output drives its own brake level bit.
// - Compare low bytes of channels 0, 2, 6 sit at DA, DD, DE.
// - Period low byte sits at D9 and feeds counter reload.
`timescale 1ns/1ps
`include "mpwm_regs.svh"
module mpwm_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic brake_pin,
    output logic [7:0] pwm_out,
    output logic irq
);
    import mpwm_pkg::*;

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    mpwm_reg_if rif ();

    mpwm_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rif(rif)
    );

    function automatic logic wr_to(input logic [7:0] idx);
        wr_to = rif.wr_en & (rif.wr_idx == idx);
    endfunction : wr_to

    // ------------------------------------------------------------
    // Software visible registers
    // ------------------------------------------------------------
    logic counter_run_ctl;
    logic load_pending;
    logic period_event_flag;
    logic [3:0] channel_invert_bit;
    mpwm_byte_t channel_brake_level;
    mpwm_cnt_t period_reload_value;
    mpwm_cnt_t channel_compare_value [8];
    mpwm_cnt_t work_compare [8];
    mpwm_cnt_t work_period;
    mpwm_cnt_t counter;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic brake_sw;
    logic brake_en;
    logic [2:0] high_sel;

    // Pin input: three stages, a change counts once stages two and three agree
    logic [2:0] brake_sync;
    logic brake_seen;

    wire wr_ctl = wr_to(`MPWM_IDX_CONTROL_ONE);
    wire ctl_clear = wr_ctl & rif.wr_data[`MPWM_BIT_CLEAR];
    wire brake_active = brake_en & (brake_seen | brake_sw);

    // Down counter reaching zero is the underflow point
    wire underflow = counter_run_ctl & ~ctl_clear & (counter == 12'h000);

    // Transfer only while load is set, at underflow
    wire do_load = underflow & load_pending;

    // ------------------------------------------------------------
    // Control register one
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_run_ctl <= 1'b0;
            channel_invert_bit <= 4'h0;
        end else if (wr_ctl) begin
            counter_run_ctl <= rif.wr_data[`MPWM_BIT_RUN];
            channel_invert_bit <= rif.wr_data[3:0];
        end
    end

    // Load clears itself after the transfer; a new write still wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_pending <= 1'b0;
        end else if (wr_ctl) begin
            load_pending <= rif.wr_data[`MPWM_BIT_LOAD];
        end else if (do_load) begin
            load_pending <= 1'b0;
        end
    end

    // Set by underflow, cleared only by writing zero; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_event_flag <= 1'b0;
        end else if (underflow) begin
            period_event_flag <= 1'b1;
        end else if (wr_ctl & ~rif.wr_data[`MPWM_BIT_FLAG]) begin
            period_event_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Buffered period and compare values
    // ------------------------------------------------------------
    wire wr_high = wr_to(`MPWM_IDX_HIGH_BITS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_reload_value <= `MPWM_RST_PERIOD;
            channel_brake_level <= `MPWM_RST_BYTE;
            brake_sw <= 1'b0;
            brake_en <= 1'b0;
            high_sel <= 3'h0;
            irq_mask <= 2'b00;
            for (int i = 0; i < 8; i++) begin
                channel_compare_value[i] <= 12'h000;
            end
        end else begin
            if (wr_to(`MPWM_IDX_PERIOD_LOW)) begin
                period_reload_value[7:0] <= rif.wr_data;
            end
            // Compare low bytes of the documented channels
            if (wr_to(`MPWM_IDX_CH0_LOW)) begin
                channel_compare_value[0][7:0] <= rif.wr_data;
            end
            if (wr_to(`MPWM_IDX_CH2_LOW)) begin
                channel_compare_value[2][7:0] <= rif.wr_data;
            end
            if (wr_to(`MPWM_IDX_CH6_LOW)) begin
                channel_compare_value[6][7:0] <= rif.wr_data;
            end
            if (wr_to(`MPWM_IDX_CH4_LOW)) begin
                channel_compare_value[4][7:0] <= rif.wr_data;
            end
            // Odd channel low byte goes to the channel picked by bits 6:5
            if (wr_to(`MPWM_IDX_CH_LOW_ODD)) begin
                channel_compare_value[{rif.wr_data[6:5], 1'b1}][7:0] <= {4'h0, rif.wr_data[3:0]};
            end
            // High nibble: bit 7 picks period, else bits 6:4 pick channel; bits 3:0 the value
            if (wr_high) begin
                high_sel <= rif.wr_data[6:4];
                if (rif.wr_data[7]) begin
                    period_reload_value[11:8] <= rif.wr_data[3:0];
                end else begin
                    channel_compare_value[rif.wr_data[6:4]][11:8] <= rif.wr_data[3:0];
                end
            end
            if (wr_to(`MPWM_IDX_BRAKE_LEVELS)) begin
                channel_brake_level <= rif.wr_data;
            end
            if (wr_to(`MPWM_IDX_BRAKE_CTL)) begin
                brake_en <= rif.wr_data[0];
                brake_sw <= rif.wr_data[1];
            end
            if (wr_to(`MPWM_IDX_IRQ_MASK)) begin
                irq_mask <= rif.wr_data[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Counter and working registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter <= 12'h000;
            work_period <= `MPWM_RST_PERIOD;
            for (int i = 0; i < 8; i++) begin
                work_compare[i] <= 12'h000;
            end
        end else if (ctl_clear) begin
            counter <= 12'h000;
        end else if (underflow) begin
            // Reload; buffered values only move when load is set
            if (load_pending) begin
                counter <= period_reload_value;
                work_period <= period_reload_value;
                for (int i = 0; i < 8; i++) begin
                    work_compare[i] <= channel_compare_value[i];
                end
            end else begin
                counter <= work_period;
            end
        end else if (counter_run_ctl) begin
            counter <= counter - 12'h001;
        end
    end

    // ------------------------------------------------------------
    // Brake pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brake_sync <= 3'b000;
            brake_seen <= 1'b0;
        end else begin
            brake_sync <= {brake_sync[1:0], brake_pin};
            if (brake_sync[1] == brake_sync[2]) begin
                brake_seen <= brake_sync[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    logic [7:0] raw_out;
    logic [7:0] inv_mask;
    assign inv_mask = {1'b0, channel_invert_bit[3], 1'b0, channel_invert_bit[2],
        1'b0, channel_invert_bit[1], 1'b0, channel_invert_bit[0]};

    // Compare, then invert, then brake override
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            raw_out[i] = (counter < work_compare[i]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= 8'h00;
        end else if (brake_active) begin
            // Brake levels take over every channel
            pwm_out <= channel_brake_level;
        end else begin
            pwm_out <= raw_out ^ inv_mask;
        end
    end

    // ------------------------------------------------------------
    // Interrupts: sticky status, write one to clear, set wins
    // ------------------------------------------------------------
    wire wr_stat = wr_to(`MPWM_IDX_IRQ_STATUS);
    wire [1:0] irq_set = {do_load, underflow};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 2'b00;
        end else begin
            irq_status <= irq_set | (irq_status & ~(wr_stat ? rif.wr_data[1:0] : 2'b00));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rif.rd_hit = 1'b1;
        rif.rd_data = 8'h00;
        case (rif.rd_idx)
            `MPWM_IDX_PERIOD_LOW: rif.rd_data = period_reload_value[7:0];
            `MPWM_IDX_CH0_LOW: rif.rd_data = channel_compare_value[0][7:0];
            `MPWM_IDX_CONTROL_ONE: rif.rd_data = {counter_run_ctl, load_pending,
                period_event_flag, 1'b0, channel_invert_bit};
            `MPWM_IDX_CH2_LOW: rif.rd_data = channel_compare_value[2][7:0];
            `MPWM_IDX_CH6_LOW: rif.rd_data = channel_compare_value[6][7:0];
            `MPWM_IDX_CH4_LOW: rif.rd_data = channel_compare_value[4][7:0];
            `MPWM_IDX_BRAKE_LEVELS: rif.rd_data = channel_brake_level;
            `MPWM_IDX_HIGH_BITS: rif.rd_data = {1'b0, high_sel,
                channel_compare_value[high_sel][11:8]};
            `MPWM_IDX_CH_LOW_ODD: rif.rd_data = counter[7:0];
            `MPWM_IDX_IRQ_STATUS: rif.rd_data = {6'h00, irq_status};
            `MPWM_IDX_IRQ_MASK: rif.rd_data = {6'h00, irq_mask};
            `MPWM_IDX_BRAKE_CTL: rif.rd_data = {5'h00, brake_seen, brake_sw, brake_en};
            default: rif.rd_hit = 1'b0;
        endcase
    end
endmodule : mpwm_top

// File: sim/mpwm_load_model.sv
// Load on the PWM pins: counts the cycles each output spends high
`timescale 1ns/1ps
module mpwm_load_model (
    input wire logic pclk,
    input wire logic clr,
    input wire logic [7:0] pwm,
    output integer highs [8]
);
    // levels seen at the power stage
    always_ff @(posedge pclk) begin
        for (int i = 0; i < 8; i++) begin
            // Four-state sum so an unknown level on a pin is not hidden
            highs[i] <= clr ? 0 : highs[i] + {31'h0, pwm[i]};
        end
    end
endmodule : mpwm_load_model

// File: sim/mpwm_top_properties.sv
// Port-level assertions for the multichannel PWM unit
`timescale 1ns/1ps
module mpwm_top_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic brake_pin,
    input wire logic [7:0] pwm_out,
    input wire logic irq
);
    logic [7:0] lvl;
    logic acc;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign acc = psel && penable;
    // Last brake level byte written, so the override can be judged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl <= 8'h00;
        end else if (acc && pwrite && pstrb[0] && paddr == 12'h37c) begin
            lvl <= pwdata[7:0];
        end
    end
    // ----
    // Bus and outputs
    // ----
    ready_always_a: assert property (pready) else $error("pready low");
    err_in_access_a: assert property (pslverr |-> acc) else $error("stray error");
    misalign_err_a: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    ctl_ok_a: assert property (acc && paddr == 12'h370 |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("control access refused");
    clear_reads_zero_a: assert property (acc && !pwrite && paddr == 12'h370 |-> !prdata[4])
        else $error("clear bit reads one");
    reset_idle_a: assert property ($rose(presetn) |-> pwm_out == 8'h00 && !irq)
        else $error("outputs active out of reset");
    brake_sw_a: assert property (acc && pwrite && pstrb[0] && paddr == 12'h3b0
        && pwdata[1:0] == 2'b11 |-> ##3 pwm_out == lvl) else $error("brake level wrong");
    mask_off_irq_a: assert property (acc && pwrite && pstrb[0] && paddr == 12'h3ac
        && pwdata[7:0] == 8'h00 |-> ##2 !irq) else $error("irq with mask clear");
    irq_seen_c: cover property ($rose(irq));
    error_seen_c: cover property (pslverr);
    pin_brake_c: cover property ($rose(brake_pin));
endmodule : mpwm_top_properties

// File: sim/mpwm_top_tb.sv
// Self-checking bench for the multichannel PWM unit
`timescale 1ns/1ps
module mpwm_top_tb;
    logic pclk, presetn, psel, penable, pwrite, brake_pin, irq, pready, pslverr, clr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0] pstrb, inv;
    logic [7:0] pwm_out, lvl, snap, exp8;
    logic [7:0] ri [7] = '{8'hd9, 8'hda, 8'hdc, 8'hdd, 8'hde, 8'hdf, 8'hed};
    int n_errors, compares, cmp [8];
    integer highs [8];
    mpwm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .brake_pin(brake_pin), .pwm_out(pwm_out),
        .irq(irq));
    mpwm_load_model load_u (.pclk(pclk), .clr(clr), .pwm(pwm_out), .highs(highs));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // High cycles over five periods of ten, inversion on even channels only
    function automatic int expd(input int ch);
        int h;
        h = 5 * cmp[ch];
        if (ch % 2 == 0 && inv[ch / 2]) h = 50 - h;
        return h;
    endfunction : expd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, {2'b00, i, 2'b00}, d);
    endtask : wreg
    task automatic rreg(input logic [7:0] i);
        apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
    endtask : rreg
    task automatic duty();
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (50) @(posedge pclk);
        @(negedge pclk);
        for (int i = 0; i < 8; i++) chk(highs[i], expd(i));
    endtask : duty
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Whole run needs about 400 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        end_sim();
    end
    initial begin
        {psel, penable, pwrite, brake_pin, clr} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        presetn = 1'b0;
        seed = 32'h6938;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ri[i]) begin
            rreg(ri[i]);
            chk(rd, (i == 0) ? 32'hff : 32'h0);
        end
        apb(1'b0, 12'h372, 8'h00);
        chk(err, 1'b1);
        $display("test reset done");
        foreach (ri[i]) begin
            seed = lfsr(seed);
            if (i != 2) wreg(ri[i], seed[7:0]);
            if (i != 2) rreg(ri[i]);
            if (i != 2) chk(rd, {24'h0, seed[7:0]});
        end
        rreg(8'hda);
        exp8 = rd[7:0];
        pstrb <= 4'he;
        wreg(8'hda, ~exp8);
        pstrb <= 4'hf;
        rreg(8'hda);
        chk(rd, {24'h0, exp8});
        $display("test registers done");
        seed = lfsr(seed);
        inv = seed[3:0];
        cmp = '{4, 0, 2, 3, 5, 0, 7, 0};
        wreg(8'hd9, 8'h09);
        wreg(8'he8, 8'h80);
        wreg(8'hed, 8'h05);
        wreg(8'he9, 8'h23);
        wreg(8'hda, 8'h04);
        wreg(8'hdd, 8'h02);
        wreg(8'hde, 8'h07);
        wreg(8'hdc, {4'hc, inv});
        repeat (12) @(posedge pclk);
        rreg(8'hdc);
        chk(rd, {24'h0, 4'ha, inv});
        duty();
        $display("test load done");
        wreg(8'hda, 8'h08);
        repeat (12) @(posedge pclk);
        duty();
        wreg(8'hdc, {4'hc, inv});
        cmp[0] = 8;
        repeat (12) @(posedge pclk);
        duty();
        $display("test buffer done");
        rreg(8'hea);
        chk(rd[1:0], 2'b11);
        chk(irq, 1'b0);
        wreg(8'heb, 8'h01);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        wreg(8'hdc, {4'h2, inv});
        wreg(8'hea, 8'h03);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        snap = pwm_out;
        repeat (30) @(posedge pclk);
        chk(pwm_out, snap);
        rreg(8'hdc);
        chk(rd, {24'h0, 4'h2, inv});
        $display("test stop done");
        wreg(8'hdc, {4'h1, inv});
        rreg(8'hdc);
        chk(rd, {24'h0, 4'h0, inv});
        rreg(8'he9);
        chk(rd, 32'h0);
        for (int i = 0; i < 8; i++) exp8[i] = (cmp[i] > 0) ^ (i % 2 == 0 && inv[i / 2]);
        chk(pwm_out, exp8);
        $display("test clear done");
        seed = lfsr(seed);
        lvl = seed[7:0];
        wreg(8'hdf, lvl);
        wreg(8'hec, 8'h03);
        repeat (3) @(posedge pclk);
        chk(pwm_out, lvl);
        wreg(8'hec, 8'h01);
        brake_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(pwm_out, lvl);
        brake_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(pwm_out, exp8);
        wreg(8'heb, 8'h00);
        $display("test brake done");
        end_sim();
    end
endmodule : mpwm_top_tb
bind mpwm_top mpwm_top_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .brake_pin(brake_pin),
    .pwm_out(pwm_out), .irq(irq));
